// [rtl/bldcp_pkg.sv]
// Package of constants and types for the brushless commutation and protection block
package bldcp_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int OSC_PERIOD_NS = 40_000;
  localparam int OSC_CYCLES = OSC_PERIOD_NS / 20;
  localparam int LATCH_DELAY_OSC = 16;
  localparam int SYNC_STAGES = 3;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam int CTRL_LATCH_EN_BIT = 0;
  localparam int CTRL_LATCH_CLR_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // Event bits of the interrupt status register
  localparam int EV_INVALID = 0;
  localparam int EV_DISABLED = 1;
  localparam int EV_OVERCUR = 2;
  localparam int EV_UNDERV = 3;
  localparam int EV_THERMAL = 4;
  localparam int EV_LATCHED = 5;
  localparam int EV_BRAKE = 6;
  localparam int EV_COUNT = 7;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic c;
    logic b;
    logic a;
  } bldcp_phase_type;

  typedef struct packed {
    bldcp_phase_type upper;
    bldcp_phase_type lower;
  } bldcp_drive_type;

  typedef enum logic [1:0] {
    BLDCP_RUN,
    BLDCP_BRAKE_WAIT,
    BLDCP_BRAKE_ON
  } bldcp_brake_type;

endpackage

// [rtl/bldcp_top.sv]
// Commutation, braking and protection logic of a three-phase motor controller
// Operation
// - Hall code selects upper and lower drives
// - Three upper, three lower drive outputs
// - Select high 60 degree, low 120 degree
// - Direction input reverses commutation per code
// - Enable high drives, low coasts
// - Brake high inhibits running, brakes motor
// - Overcurrent ends conduction for oscillator cycle
// - Fault low on six error conditions
// - Optional delayed latched shutdown on overcurrent
// - Six codes valid, two invalid
// - Direction change swaps upper and lower per phase
// - Enable low with brake low: all drives off
// - Brake first; lowers on after uppers off
`timescale 1ns/1ps
module bldcp_top
#(
  parameter int OSC_LEN = bldcp_pkg::OSC_CYCLES,
  parameter int LATCH_OSC = bldcp_pkg::LATCH_DELAY_OSC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Pins from outside
  input wire bldcp_pkg::bldcp_phase_type HALL,
  input wire logic PHASE_60,
  input wire logic DIR_FWD,
  input wire logic ENABLE,
  input wire logic BRAKE,
  input wire logic OVERCUR,
  input wire logic UNDERVOLT,
  input wire logic OVERTEMP,
  // Drives and fault
  output bldcp_pkg::bldcp_drive_type DRIVE,
  output logic FAULT_N,
  output logic OSC_START,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic IRQ
);
  import bldcp_pkg::*;

  localparam int NPIN = 10;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_r, s2_r, s3_r, pin_r;
  logic [NPIN-1:0] s1_nxt, s2_nxt, s3_nxt, pin_nxt;
  assign pin_raw = {OVERTEMP, UNDERVOLT, OVERCUR, BRAKE, ENABLE, DIR_FWD, PHASE_60, HALL};

  // Stages two and three must agree, which filters single-cycle glitches
  always_comb begin
    s1_nxt = pin_raw;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    pin_nxt = pin_r;
    for (int i = 0; i < NPIN; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        pin_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pin_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      pin_r <= pin_nxt;
    end
  end

  logic [2:0] hall;
  logic sel60, fwd, en, brk, oc, uv, ot;
  assign hall = pin_r[2:0];
  assign sel60 = pin_r[3];
  assign fwd = pin_r[4];
  assign en = pin_r[5];
  assign brk = pin_r[6];
  assign oc = pin_r[7];
  assign uv = pin_r[8];
  assign ot = pin_r[9];

  // ------------------------------------------------------------
  // Position decoder
  // ------------------------------------------------------------
  logic [2:0] code120;
  logic valid;
  bldcp_drive_type fwd_drive, cmd_drive;

  // 60 degree sensors map onto 120 degree codes by inverting the middle sensor
  always_comb begin
    code120 = sel60 ? {hall[2], ~hall[1], hall[0]} : hall;
    valid = !(code120 == 3'h0 || code120 == 3'h7);
    fwd_drive = '0;
    case (code120)
      3'h1: begin
        fwd_drive.upper = 3'h1;
        fwd_drive.lower = 3'h4;
      end
      3'h3: begin
        fwd_drive.upper = 3'h2;
        fwd_drive.lower = 3'h4;
      end
      3'h2: begin
        fwd_drive.upper = 3'h2;
        fwd_drive.lower = 3'h1;
      end
      3'h6: begin
        fwd_drive.upper = 3'h4;
        fwd_drive.lower = 3'h1;
      end
      3'h4: begin
        fwd_drive.upper = 3'h4;
        fwd_drive.lower = 3'h2;
      end
      3'h5: begin
        fwd_drive.upper = 3'h1;
        fwd_drive.lower = 3'h2;
      end
      default: fwd_drive = '0;
    endcase
    // Reverse swaps upper and lower of each phase
    cmd_drive = fwd ? fwd_drive : {fwd_drive.lower, fwd_drive.upper};
  end

  // ------------------------------------------------------------
  // Oscillator and current limit
  // ------------------------------------------------------------
  logic [15:0] osc_r, osc_nxt;
  logic cut_r, cut_nxt;
  logic [7:0] ocnt_r, ocnt_nxt;
  logic latch_r, latch_nxt;
  logic osc_wrap;
  logic latch_en, latch_clr;
  logic [7:0] ctrl_r, ctrl_nxt;

  assign osc_wrap = (osc_r == 16'(OSC_LEN - 1));
  assign latch_en = ctrl_r[CTRL_LATCH_EN_BIT];
  assign latch_clr = WR && ADDR == ADDR_CTRL && WDATA[CTRL_LATCH_CLR_BIT];

  always_comb begin
    osc_nxt = osc_wrap ? 16'h0000 : osc_r + 16'h0001;
    cut_nxt = cut_r;
    ocnt_nxt = ocnt_r;
    latch_nxt = latch_r;
    if (osc_wrap) begin
      cut_nxt = oc;
      // A cycle counts as sustained overcurrent if it was cut at any point
      if (cut_r || oc) begin
        ocnt_nxt = ocnt_r + 8'h01;
      end else begin
        ocnt_nxt = 8'h00;
      end
    end else if (oc) begin
      cut_nxt = 1'b1;
    end
    // Set beats a clear in the same cycle, so a shutdown is never lost
    if (latch_en && ocnt_r == 8'(LATCH_OSC)) begin
      latch_nxt = 1'b1;
      ocnt_nxt = 8'h00;
    end else if (latch_clr) begin
      latch_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      osc_r <= 16'h0000;
      cut_r <= 1'b0;
      ocnt_r <= 8'h00;
      latch_r <= 1'b0;
    end else begin
      osc_r <= osc_nxt;
      cut_r <= cut_nxt;
      ocnt_r <= ocnt_nxt;
      latch_r <= latch_nxt;
    end
  end

  // ------------------------------------------------------------
  // Drive selection and brake sequencing
  // ------------------------------------------------------------
  bldcp_brake_type brk_r, brk_nxt;
  bldcp_drive_type drv_r, drv_nxt;
  logic fault_r, fault_nxt;
  logic inhibit;

  assign inhibit = cut_r || oc || latch_r || uv || ot || !valid;

  always_comb begin
    brk_nxt = brk_r;
    drv_nxt = '0;
    case (brk_r)
      BLDCP_RUN: begin
        if (brk) begin
          brk_nxt = BLDCP_BRAKE_WAIT;
        end else if (en && !inhibit) begin
          drv_nxt = cmd_drive;
        end else begin
          drv_nxt = '0;
        end
      end
      // Uppers are already off here; lowers wait one cycle so the bridge never shoots through
      BLDCP_BRAKE_WAIT: begin
        brk_nxt = brk ? BLDCP_BRAKE_ON : BLDCP_RUN;
      end
      BLDCP_BRAKE_ON: begin
        if (brk && drv_r.upper == 3'b000) begin
          drv_nxt.lower = 3'b111;
        end else begin
          brk_nxt = BLDCP_RUN;
        end
      end
      default: brk_nxt = BLDCP_RUN;
    endcase
    fault_nxt = !(!valid || !en || oc || uv || ot || latch_r);
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      brk_r <= BLDCP_RUN;
      drv_r <= '0;
      fault_r <= 1'b1;
    end else begin
      brk_r <= brk_nxt;
      drv_r <= drv_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign DRIVE = drv_r;
  assign FAULT_N = fault_r;
  assign OSC_START = (osc_r == 16'h0000);

  // ------------------------------------------------------------
  // Registers and interrupt
  // ------------------------------------------------------------
  logic [EV_COUNT-1:0] ev, ist_r, ist_nxt, mask_r, mask_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  assign ev = {brk, latch_r, ot, uv, oc, !en, !valid};

  // A new event beats a write-one clear in the same cycle
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    ist_nxt = ist_r;
    if (WR && ADDR == ADDR_CTRL) begin
      ctrl_nxt = {7'h00, WDATA[CTRL_LATCH_EN_BIT]};
    end
    if (WR && ADDR == ADDR_IRQ_MASK) begin
      mask_nxt = WDATA[EV_COUNT-1:0];
    end
    if (WR && ADDR == ADDR_IRQ_STAT) begin
      ist_nxt = ist_r & ~WDATA[EV_COUNT-1:0];
    end
    ist_nxt = ist_nxt | ev;
    rdata_nxt = 8'h00;
    if (RD) begin
      case (ADDR)
        ADDR_CTRL: rdata_nxt = ctrl_r;
        ADDR_STATUS: rdata_nxt = {1'b0, ev};
        ADDR_IRQ_STAT: rdata_nxt = {1'b0, ist_r};
        ADDR_IRQ_MASK: rdata_nxt = {1'b0, mask_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ctrl_r <= CTRL_RESET;
      mask_r <= MASK_RESET[EV_COUNT-1:0];
      ist_r <= '0;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      ist_r <= ist_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;
  assign IRQ = |(ist_r & mask_r);

endmodule // bldcp_top

// [tb/bldcp_asserts.sv]
// Checker of the drive and protection outputs
`timescale 1ns/1ps
module bldcp_asserts
  import bldcp_pkg::*;
#(
  parameter int OSC_LEN = OSC_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Watched pins
  input wire bldcp_phase_type HALL,
  input wire logic PHASE_60,
  input wire logic ENABLE,
  input wire logic BRAKE,
  input wire logic OVERCUR,
  input wire bldcp_drive_type DRIVE,
  input wire logic FAULT_N,
  input wire logic OSC_START
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Counter, since the period can exceed any plain delay
  int gap_r;
  logic seen_r;
  always_ff @(posedge CLK) begin
    gap_r <= (!NRST || OSC_START) ? 0 : gap_r + 1;
    seen_r <= NRST && (seen_r || OSC_START);
  end
  property p_osc; OSC_START && seen_r |-> gap_r == OSC_LEN - 1; endproperty
  a_osc: assert property (p_osc) else $error("oscillator period wrong");
  property p_cross; (DRIVE.upper & DRIVE.lower) == 3'h0; endproperty
  a_cross: assert property (p_cross) else $error("upper and lower of a phase both on");
  property p_order; DRIVE.lower == 3'h7 && $past(DRIVE.lower) != 3'h7 |-> $past(DRIVE.upper) == 3'h0; endproperty
  a_order: assert property (p_order) else $error("lowers on before uppers off");
  property p_brake; BRAKE [*8] |-> DRIVE == 6'h07; endproperty
  a_brake: assert property (p_brake) else $error("brake drive pattern wrong");
  property p_enable; (!ENABLE && !BRAKE) [*8] |-> DRIVE == 6'h00; endproperty
  a_enable: assert property (p_enable) else $error("drives on while disabled");
  property p_fault; (!ENABLE && !BRAKE) [*8] |-> !FAULT_N; endproperty
  a_fault: assert property (p_fault) else $error("fault missing while disabled");
  property p_oc; (OVERCUR && !BRAKE) [*8] |-> DRIVE == 6'h00 && !FAULT_N; endproperty
  a_oc: assert property (p_oc) else $error("conduction during overcurrent");
  property p_invalid; (!BRAKE && !PHASE_60 && (HALL == 3'h0 || HALL == 3'h7)) [*8] |-> DRIVE == 6'h00 && !FAULT_N;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid code not refused");
  property p_pair; DRIVE.upper != 3'h0 |-> $onehot(DRIVE.upper) && $onehot(DRIVE.lower); endproperty
  a_pair: assert property (p_pair) else $error("more than one switch per side");
endmodule // bldcp_asserts

bind bldcp_top bldcp_asserts #(.OSC_LEN(OSC_LEN)) i_chk (.CLK, .NRST, .HALL, .PHASE_60, .ENABLE, .BRAKE,
  .OVERCUR, .DRIVE, .FAULT_N, .OSC_START);

// [tb/bldcp_hall_model.sv]
// Rotor position sensors seen from the controller
`timescale 1ns/1ps
module bldcp_hall_model
  import bldcp_pkg::*;
(
  // Rotor state
  input wire logic [2:0] step,
  input wire logic p60,
  input wire logic opened,
  // Sensor lines
  output bldcp_phase_type hall
);
  // ------------------------------------------------------------
  // Sensor code
  // ------------------------------------------------------------
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  // Open lines float high through the pull-ups, hence all ones
  assign hall = opened ? 3'h7 : (seq[step] ^ {1'b0, p60, 1'b0});
endmodule // bldcp_hall_model

// [tb/tb_bldcp_top.sv]
// Self-checking bench of the commutation and protection block
`timescale 1ns/1ps
module tb_bldcp_top;
  import bldcp_pkg::*;
  localparam int OSC = 20;
  logic clk = 1'b0, nrst = 1'b0, p60 = 1'b0, dir = 1'b1, en = 1'b1, brk = 1'b0, oc = 1'b0, uv = 1'b0, ot = 1'b0;
  logic opened = 1'b0, wr = 1'b0, rd = 1'b0, fault_n, osc_start, irq;
  logic [2:0] step = 3'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, d;
  bldcp_phase_type hall;
  bldcp_drive_type drive;
  int err_total = 0, cmp_count = 0, cycles = 0;
  // ------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------
  bldcp_hall_model i_hall (.step(step), .p60(p60), .opened(opened), .hall(hall));
  bldcp_top #(.OSC_LEN(OSC), .LATCH_OSC(2)) i_dut (.CLK(clk), .NRST(nrst), .HALL(hall), .PHASE_60(p60),
    .DIR_FWD(dir), .ENABLE(en), .BRAKE(brk), .OVERCUR(oc), .UNDERVOLT(uv), .OVERTEMP(ot), .DRIVE(drive),
    .FAULT_N(fault_n), .OSC_START(osc_start), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // Forward table: uppers A,B,B,C,C,A and lowers C,C,A,A,B,B
  function automatic logic [7:0] exp_drv(input logic [2:0] s, input logic f);
    logic [2:0] u, l;
    u = 3'h1 << ((s + 1) / 2 % 3);
    l = 3'h1 << ((s + 4) / 2 % 3);
    return f ? {2'h0, u, l} : {2'h0, l, u};
  endfunction
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_table;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 6; s++) begin
        p60 <= m[1];
        dir <= m[0];
        step <= 3'(s);
        cyc(8);
        chk("drive", {2'h0, drive}, exp_drv(3'(s), m[0]));
        chk("fault", {7'h0, fault_n}, 8'h01);
      end
    end
  endtask
  task automatic t_faults;
    p60 <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      opened <= (k == 0);
      en <= (k != 1);
      uv <= (k == 2);
      ot <= (k == 3);
      cyc(8);
      chk("fault", {7'h0, fault_n}, 8'h00);
      chk("drive", {2'h0, drive}, 8'h00);
    end
    ot <= 1'b0;
    step <= 3'h0;
    dir <= 1'b1;
    cyc(8);
  endtask
  task automatic t_brake;
    brk <= 1'b1;
    for (int n = 0; n < 10 && drive.upper !== 3'h0; n++) @(posedge clk);
    chk("early lows", {7'h0, drive.lower == 3'h7}, 8'h00);
    cyc(2);
    chk("brake", {2'h0, drive}, 8'h07);
    en <= 1'b0;
    cyc(8);
    chk("brake prio", {2'h0, drive}, 8'h07);
    brk <= 1'b0;
    en <= 1'b1;
    cyc(8);
    chk("release", {2'h0, drive}, exp_drv(3'h0, 1'b1));
  endtask
  task automatic t_oc;
    wr_reg(ADDR_IRQ_STAT, 8'hFF);
    wr_reg(ADDR_IRQ_MASK, 8'h04);
    cyc(2);
    chk("irq idle", {7'h0, irq}, 8'h00);
    @(posedge clk iff osc_start);
    cyc(4);
    oc <= 1'b1;
    cyc(2);
    oc <= 1'b0;
    cyc(8);
    chk("cut", {2'h0, drive}, 8'h00);
    @(posedge clk iff osc_start);
    cyc(4);
    chk("resume", {2'h0, drive}, exp_drv(3'h0, 1'b1));
    chk("irq set", {7'h0, irq}, 8'h01);
    rd_reg(ADDR_IRQ_STAT);
    chk("stat", d, 8'h04);
    wr_reg(ADDR_IRQ_MASK, 8'h00);
    cyc(2);
    chk("irq masked", {7'h0, irq}, 8'h00);
    wr_reg(ADDR_IRQ_MASK, 8'h04);
    wr_reg(ADDR_IRQ_STAT, 8'h04);
    cyc(2);
    chk("irq clear", {7'h0, irq}, 8'h00);
  endtask
  task automatic t_latch;
    wr_reg(ADDR_CTRL, 8'h01);
    oc <= 1'b1;
    cyc(4 * OSC);
    oc <= 1'b0;
    cyc(2 * OSC);
    chk("latched", {1'h0, fault_n, drive}, 8'h00);
    rd_reg(ADDR_STATUS);
    chk("latch bit", {7'h0, d[EV_LATCHED]}, 8'h01);
    wr_reg(ADDR_IRQ_STAT, 8'h20);
    rd_reg(ADDR_IRQ_STAT);
    chk("latch sticky", {7'h0, d[EV_LATCHED]}, 8'h01);
    wr_reg(ADDR_CTRL, 8'h02);
    cyc(2 * OSC);
    chk("unlatched", {1'h0, fault_n, drive}, 8'h40 | exp_drv(3'h0, 1'b1));
    rd_reg(4'hF);
    chk("unmapped", d, 8'h00);
  endtask
  initial begin
    cyc(4);
    nrst <= 1'b1;
    rd_reg(ADDR_CTRL);
    chk("ctrl rst", d, CTRL_RESET);
    rd_reg(ADDR_IRQ_MASK);
    chk("mask rst", d, MASK_RESET);
    t_table();
    t_faults();
    t_brake();
    t_oc();
    t_latch();
    print_verdict();
  end
endmodule // tb_bldcp_top
